//--- pkg/i2c_seq_pkg.sv
// Constants, types and register layout for the two-wire master sequencer
`default_nettype none
package i2c_seq_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte addresses
  localparam logic [3:0] CTRL_ADDR = 4'h0;
  localparam logic [3:0] STAT_ADDR = 4'h4;
  localparam logic [3:0] DIV_ADDR = 4'h8;
  localparam logic [3:0] BUF_ADDR = 4'hc;

  // Bit positions in the second control register
  localparam int START_POS = 0;
  localparam int RESTART_POS = 1;
  localparam int STOP_POS = 2;
  localparam int RX_EN_POS = 3;
  localparam int ACK_SEQ_POS = 4;
  localparam int ACK_DATA_POS = 5;
  localparam int ACK_STAT_POS = 6;

  // Bit positions in the serial status register
  localparam int BF_POS = 0;
  localparam int START_DET_POS = 3;
  localparam int WRITE_COLLISION_FLAG_POS = 4;
  localparam int RX_OV_POS = 5;
  localparam int BUS_COLL_POS = 6;
  localparam int SER_INT_POS = 7;

  ////////////////////////////////////////////////////////////////////////////
  // Values after reset and counts
  localparam logic [6:0] DIV_RESET = 7'h3f;
  localparam logic [6:0] BAUD_SHORT_MASK = 7'h3f; // Divisor bits 5:0
  localparam logic [6:0] BAUD_STEP = 7'h01;       // Two steps per instruction cycle
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [31:0] READ_RESET = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer phases
  typedef enum logic [4:0] {
    PH_IDLE,
    PH_START_WAIT, PH_START_HOLD,
    PH_RS_LOW, PH_RS_SDA, PH_RS_REL, PH_RS_HIGH, PH_RS_HOLD,
    PH_TX_LOW, PH_TX_REL, PH_TX_HIGH,
    PH_RX_LOW, PH_RX_REL, PH_RX_HIGH,
    PH_AK_LOW, PH_AK_REL, PH_AK_HIGH,
    PH_SP_LOW, PH_SP_CNT, PH_SP_REL, PH_SP_HIGH, PH_SP_END
  } phase_t;

  // Avalon-MM slave request and answer
  typedef struct packed {
    logic read;
    logic write;
    logic [3:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } avs_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } avs_rsp_t;

  // Open-drain line sides
  typedef struct packed {
    logic scl_in;
    logic sda_in;
  } line_in_t;

  typedef struct packed {
    logic scl_out;
    logic scl_oe;
    logic sda_out;
    logic sda_oe;
  } line_out_t;

  // Whole state of the sequencer
  typedef struct packed {
    phase_t phase;
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic [6:0] baud_cnt;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] buffer;
    logic [6:0] divisor;
    logic start_req;
    logic restart_req;
    logic stop_req;
    logic rx_en;
    logic ack_seq;
    logic ack_data;
    logic ack_status;
    logic buffer_full;
    logic start_det;
    logic write_collision_flag;
    logic rx_ov;
    logic bus_coll;
    logic ser_int;
    line_out_t drive;
    avs_rsp_t rsp;
  } seq_state_t;

endpackage : i2c_seq_pkg
`default_nettype wire

//--- logic/i2c_master_sequencer.sv
// Two-wire master sequencer: start, repeated start, byte send and receive
//
// Contract
// - Start request checks both lines high, loads counter from divisor 6:0, counts.
// - Timeout with lines high: pull data low, clock high; set start-detected bit 3.
// - Reload, count again; at timeout clear start request, stop counter, data low.
// - Line low at start, or clock low before data low: collision, abort, idle.
// - Buffer write during start, restart, send or receive: no change, write collision.
// - Low five control bits ignored until the running sequence or byte completes.
// - Repeated start acts only from idle; requested otherwise it has no effect.
// - Restart: clock low, then load divisor 5:0, release data; data high frees clock.
// - Clock high: load 6:0, both high one period, data low one period, clear request.
// - Restart sets start-detected on the pattern; interrupt flag waits for timeout.
// - Restart collision: data low as clock rises, or clock falls before data low.
// - Buffer write starts a byte: buffer-full set, baud counter starts timing.
// - Each bit placed after clock falls; clock low one period, high one period.
// - On eighth falling edge clear buffer-full and release data for acknowledge.
// - Ninth falling edge samples data into acknowledge status bit 6.
// - After ninth clock set interrupt flag, stop counter, clock low, data unchanged.
// - Receiving, each counter timeout toggles clock; data shifts into shift register.
// - After eighth fall: clear receive enable, load buffer, set full and interrupt, idle.
// - Reading the buffer after a reception clears buffer-full.
// - Byte received while buffer-full still set raises receive overflow.
// - Baud counter steps twice per instruction cycle, stops at zero until reloaded.
`default_nettype none
module i2c_master_sequencer
  import i2c_seq_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Register bus
  input wire avs_req_t bus_req,
  output avs_rsp_t bus_rsp,
  // Open-drain bus lines
  input wire line_in_t line_in,
  output line_out_t line_out
);

  ////////////////////////////////////////////////////////////////////////////
  seq_state_t st;
  seq_state_t next_st;

  // Outputs straight from the state register
  assign bus_rsp = st.rsp;
  assign line_out = st.drive;

  ////////////////////////////////////////////////////////////////////////////
  // Register images for read-back
  function automatic logic [31:0] ctrl_word(input seq_state_t s);
    logic [31:0] w;
    w = READ_RESET;
    w[START_POS] = s.start_req;
    w[RESTART_POS] = s.restart_req;
    w[STOP_POS] = s.stop_req;
    w[RX_EN_POS] = s.rx_en;
    w[ACK_SEQ_POS] = s.ack_seq;
    w[ACK_DATA_POS] = s.ack_data;
    w[ACK_STAT_POS] = s.ack_status;
    return w;
  endfunction : ctrl_word

  function automatic logic [31:0] stat_word(input seq_state_t s);
    logic [31:0] w;
    w = READ_RESET;
    w[BF_POS] = s.buffer_full;
    w[START_DET_POS] = s.start_det;
    w[WRITE_COLLISION_FLAG_POS] = s.write_collision_flag;
    w[RX_OV_POS] = s.rx_ov;
    w[BUS_COLL_POS] = s.bus_coll;
    w[SER_INT_POS] = s.ser_int;
    return w;
  endfunction : stat_word

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb
  begin
    logic scl_hi;
    logic sda_hi;
    logic timeout;
    logic collide;
    logic busy;
    logic acc;
    logic wr;
    logic rd;
    logic [6:0] load_long;
    logic [6:0] load_short;
    logic [31:0] wd;
    next_st = st;
    // Only the second stage of each synchroniser is looked at
    next_st.scl_sync = {st.scl_sync[0], line_in.scl_in};
    next_st.sda_sync = {st.sda_sync[0], line_in.sda_in};
    scl_hi = st.scl_sync[1];
    sda_hi = st.sda_sync[1];
    collide = 1'b0;
    load_long = st.divisor;
    load_short = st.divisor & BAUD_SHORT_MASK;
    wd = bus_req.writedata;
    busy = (st.phase != PH_IDLE) || st.start_req || st.restart_req || st.stop_req ||
           st.rx_en || st.ack_seq;

    // counter steps down, halts at zero
    timeout = (st.baud_cnt == 7'h00);
    if (!timeout)
      next_st.baud_cnt = st.baud_cnt - BAUD_STEP;

    // Bus handshake: one wait cycle, then the access is taken
    acc = (bus_req.read || bus_req.write) && !st.rsp.waitrequest;
    wr = acc && bus_req.write && bus_req.byteenable[0];
    rd = acc && bus_req.read;
    next_st.rsp.waitrequest = 1'b1;
    if ((bus_req.read || bus_req.write) && st.rsp.waitrequest)
    begin
      next_st.rsp.waitrequest = 1'b0;
      case (bus_req.address)
        CTRL_ADDR: next_st.rsp.readdata = ctrl_word(st);
        STAT_ADDR: next_st.rsp.readdata = stat_word(st);
        DIV_ADDR: next_st.rsp.readdata = {25'h0000000, st.divisor};
        BUF_ADDR: next_st.rsp.readdata = {24'h000000, st.buffer};
        default: next_st.rsp.readdata = READ_RESET;
      endcase
    end

    // Software writes land first so a hardware set in the same cycle wins
    if (wr)
    begin
      case (bus_req.address)
        CTRL_ADDR:
        begin
          next_st.ack_data = wd[ACK_DATA_POS];
          if (!busy)
          begin
            next_st.start_req = wd[START_POS];
            next_st.restart_req = wd[RESTART_POS];
            next_st.stop_req = wd[STOP_POS];
            next_st.rx_en = wd[RX_EN_POS];
            next_st.ack_seq = wd[ACK_SEQ_POS];
          end
        end
        STAT_ADDR:
        begin
          // Write one to clear
          if (wd[WRITE_COLLISION_FLAG_POS])
            next_st.write_collision_flag = 1'b0;
          if (wd[RX_OV_POS])
            next_st.rx_ov = 1'b0;
          if (wd[BUS_COLL_POS])
            next_st.bus_coll = 1'b0;
          if (wd[SER_INT_POS])
            next_st.ser_int = 1'b0;
        end
        DIV_ADDR: next_st.divisor = wd[6:0];
        default: ;
      endcase
    end

    if (rd && (bus_req.address == BUF_ADDR) && (st.phase == PH_IDLE))
      next_st.buffer_full = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // Line sequencing
    case (st.phase)
      PH_IDLE:
      begin
        if (st.start_req)
        begin
          if (scl_hi && sda_hi)
          begin
            next_st.baud_cnt = load_long;
            next_st.drive.scl_oe = 1'b0;
            next_st.drive.sda_oe = 1'b0;
            next_st.phase = PH_START_WAIT;
          end
          else
            collide = 1'b1;
        end
        else if (st.restart_req)
        begin
          next_st.drive.scl_oe = 1'b1;
          next_st.phase = PH_RS_LOW;
        end
        else if (st.stop_req)
        begin
          next_st.drive.sda_oe = 1'b1;
          next_st.phase = PH_SP_LOW;
        end
        else if (st.rx_en)
        begin
          next_st.drive.scl_oe = 1'b1;
          next_st.drive.sda_oe = 1'b0;
          next_st.bit_cnt = 4'h0;
          next_st.baud_cnt = load_long;
          next_st.phase = PH_RX_LOW;
        end
        else if (st.ack_seq)
        begin
          next_st.drive.scl_oe = 1'b1;
          next_st.drive.sda_oe = !st.ack_data;
          next_st.baud_cnt = load_long;
          next_st.phase = PH_AK_LOW;
        end
      end
      PH_START_WAIT:
      begin
        if (!scl_hi)
          collide = 1'b1;
        else if (!sda_hi || timeout)
        begin
          next_st.drive.sda_oe = 1'b1;
          next_st.start_det = 1'b1;
          next_st.baud_cnt = load_long;
          next_st.phase = PH_START_HOLD;
        end
      end
      PH_START_HOLD:
      begin
        // done: request cleared, data held low
        if (timeout)
        begin
          next_st.start_req = 1'b0;
          next_st.ser_int = 1'b1;
          next_st.phase = PH_IDLE;
        end
      end
      PH_RS_LOW:
      begin
        // clock seen low: short load, data released
        if (!scl_hi)
        begin
          next_st.baud_cnt = load_short;
          next_st.drive.sda_oe = 1'b0;
          next_st.phase = PH_RS_SDA;
        end
      end
      PH_RS_SDA:
      begin
        if (timeout)
        begin
          if (sda_hi)
          begin
            next_st.drive.scl_oe = 1'b0;
            next_st.phase = PH_RS_REL;
          end
          else
            collide = 1'b1;
        end
      end
      PH_RS_REL:
      begin
        if (scl_hi)
        begin
          if (!sda_hi)
            collide = 1'b1;
          else
          begin
            next_st.baud_cnt = load_long;
            next_st.phase = PH_RS_HIGH;
          end
        end
      end
      PH_RS_HIGH:
      begin
        if (!scl_hi || !sda_hi)
          collide = 1'b1;
        else if (timeout)
        begin
          next_st.drive.sda_oe = 1'b1;
          next_st.baud_cnt = load_long;
          next_st.phase = PH_RS_HOLD;
        end
      end
      PH_RS_HOLD:
      begin
        if (!sda_hi && scl_hi)
          next_st.start_det = 1'b1;
        if (timeout)
        begin
          next_st.restart_req = 1'b0;
          next_st.ser_int = 1'b1;
          next_st.phase = PH_IDLE;
        end
      end
      PH_TX_LOW:
      begin
        // bit follows the fall by a cycle, so no false start or stop
        // ninth slot left free for the acknowledge
        next_st.drive.sda_oe = (st.bit_cnt != ACK_BIT) && !st.shift[7];
        // low for one period, then release
        if (timeout)
        begin
          next_st.drive.scl_oe = 1'b0;
          next_st.phase = PH_TX_REL;
        end
      end
      PH_TX_REL:
      begin
        // High time counts only once the clock is really high
        if (scl_hi)
        begin
          next_st.baud_cnt = load_long;
          next_st.phase = PH_TX_HIGH;
        end
      end
      PH_TX_HIGH:
      begin
        if (timeout)
        begin
          next_st.drive.scl_oe = 1'b1;
          if (st.bit_cnt == ACK_BIT)
          begin
            next_st.ack_status = sda_hi;
            next_st.ser_int = 1'b1;
            next_st.phase = PH_IDLE;
          end
          else
          begin
            next_st.bit_cnt = st.bit_cnt + 4'h1;
            next_st.shift = {st.shift[6:0], 1'b0};
            // eighth fall: buffer empty, data freed next cycle
            if (st.bit_cnt == LAST_DATA_BIT)
              next_st.buffer_full = 1'b0;
            next_st.baud_cnt = load_long;
            next_st.phase = PH_TX_LOW;
          end
        end
      end
      PH_RX_LOW:
      begin
        if (timeout)
        begin
          next_st.drive.scl_oe = 1'b0;
          next_st.phase = PH_RX_REL;
        end
      end
      PH_RX_REL:
      begin
        if (scl_hi)
        begin
          next_st.baud_cnt = load_long;
          next_st.phase = PH_RX_HIGH;
        end
      end
      PH_RX_HIGH:
      begin
        if (timeout)
        begin
          next_st.shift = {st.shift[6:0], sda_hi};
          next_st.drive.scl_oe = 1'b1;
          if (st.bit_cnt == LAST_DATA_BIT)
          begin
            next_st.rx_en = 1'b0;
            next_st.buffer = {st.shift[6:0], sda_hi};
            if (st.buffer_full)
              next_st.rx_ov = 1'b1;
            next_st.buffer_full = 1'b1;
            next_st.ser_int = 1'b1;
            next_st.phase = PH_IDLE;
          end
          else
          begin
            next_st.bit_cnt = st.bit_cnt + 4'h1;
            next_st.baud_cnt = load_long;
            next_st.phase = PH_RX_LOW;
          end
        end
      end
      PH_AK_LOW:
      begin
        if (timeout)
        begin
          next_st.drive.scl_oe = 1'b0;
          next_st.phase = PH_AK_REL;
        end
      end
      PH_AK_REL:
      begin
        if (scl_hi)
        begin
          next_st.baud_cnt = load_long;
          next_st.phase = PH_AK_HIGH;
        end
      end
      PH_AK_HIGH:
      begin
        if (timeout)
        begin
          next_st.drive.scl_oe = 1'b1;
          next_st.ack_seq = 1'b0;
          next_st.ser_int = 1'b1;
          next_st.phase = PH_IDLE;
        end
      end
      PH_SP_LOW:
      begin
        if (!sda_hi)
        begin
          next_st.baud_cnt = load_long;
          next_st.phase = PH_SP_CNT;
        end
      end
      PH_SP_CNT:
      begin
        if (timeout)
        begin
          next_st.drive.scl_oe = 1'b0;
          next_st.phase = PH_SP_REL;
        end
      end
      PH_SP_REL:
      begin
        if (scl_hi)
        begin
          next_st.baud_cnt = load_long;
          next_st.phase = PH_SP_HIGH;
        end
      end
      PH_SP_HIGH:
      begin
        if (timeout)
        begin
          next_st.drive.sda_oe = 1'b0;
          next_st.baud_cnt = load_long;
          next_st.phase = PH_SP_END;
        end
      end
      PH_SP_END:
      begin
        // Bus free again: start pattern no longer current
        if (timeout)
        begin
          next_st.stop_req = 1'b0;
          next_st.start_det = 1'b0;
          next_st.ser_int = 1'b1;
          next_st.phase = PH_IDLE;
        end
      end
      default: next_st.phase = PH_IDLE;
    endcase

    if (collide)
    begin
      next_st.bus_coll = 1'b1;
      next_st.start_req = 1'b0;
      next_st.restart_req = 1'b0;
      next_st.stop_req = 1'b0;
      next_st.rx_en = 1'b0;
      next_st.ack_seq = 1'b0;
      next_st.drive.scl_oe = 1'b0;
      next_st.drive.sda_oe = 1'b0;
      next_st.phase = PH_IDLE;
    end

    // Buffer write: launch a byte or report collision
    if (wr && (bus_req.address == BUF_ADDR))
    begin
      if (busy)
        next_st.write_collision_flag = 1'b1;
      else
      begin
        next_st.buffer = wd[7:0];
        next_st.shift = wd[7:0];
        next_st.buffer_full = 1'b1;
        next_st.bit_cnt = 4'h0;
        next_st.baud_cnt = load_long;
        // clock low first; the first bit follows a cycle later
        next_st.drive.scl_oe = 1'b1;
        next_st.phase = PH_TX_LOW;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      st <= '0;
      st.phase <= PH_IDLE;
      st.scl_sync <= 2'b11;
      st.sda_sync <= 2'b11;
      st.divisor <= DIV_RESET;
      st.rsp.waitrequest <= 1'b1;
      st.rsp.readdata <= READ_RESET;
    end
    else
      st <= next_st;
  end

endmodule : i2c_master_sequencer
`default_nettype wire

//--- sim/i2c_seq_asserts.sv
// Port checker for the two-wire master sequencer
`default_nettype none
module i2c_seq_asserts
  import i2c_seq_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Register bus
  input wire avs_req_t bus_req,
  input wire avs_rsp_t bus_rsp,
  // Bus lines
  input wire line_in_t line_in,
  input wire line_out_t line_out
);
  logic [6:0] div;
  logic [7:0] rel_cnt;
  logic [7:0] low_cnt;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  // Shadow divisor and run lengths of the clock release and the clock pull, saturating
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      div <= DIV_RESET;
      rel_cnt <= 8'h00;
      low_cnt <= 8'h00;
    end
    else
    begin
      if (bus_req.write && !bus_rsp.waitrequest && bus_req.address == DIV_ADDR
          && bus_req.byteenable[0])
        div <= bus_req.writedata[6:0];
      rel_cnt <= line_out.scl_oe ? 8'h00 : rel_cnt + {7'h00, rel_cnt != 8'hff};
      low_cnt <= !line_out.scl_oe ? 8'h00 : low_cnt + {7'h00, low_cnt != 8'hff};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus answers
  property p_one_wait;
    (bus_req.read || bus_req.write) && bus_rsp.waitrequest |=> !bus_rsp.waitrequest;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("bus answer late");
  property p_short_low;
    !bus_rsp.waitrequest |=> bus_rsp.waitrequest;
  endproperty
  a_short_low: assert property (p_short_low) else $error("wait low too long");
  property p_no_request;
    !(bus_req.read || bus_req.write) && bus_rsp.waitrequest |=> bus_rsp.waitrequest;
  endproperty
  a_no_request: assert property (p_no_request) else $error("answer without request");
  property p_upper_zero;
    !bus_rsp.waitrequest && bus_req.read |-> bus_rsp.readdata[31:8] == 24'h000000;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
  property p_hole;
    !bus_rsp.waitrequest && bus_req.read && bus_req.address[1:0] != 2'h0
      |-> bus_rsp.readdata == 32'h0;
  endproperty
  a_hole: assert property (p_hole) else $error("unmapped read not zero");

  ////////////////////////////////////////////////////////////////////////////
  // Line timing
  property p_open_drain;
    !line_out.scl_out && !line_out.sda_out;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("line driven high");
  property p_high_time;
    $rose(line_out.scl_oe) |-> rel_cnt >= {1'b0, div};
  endproperty
  a_high_time: assert property (p_high_time) else $error("clock high too short");
  property p_low_time;
    $fell(line_out.scl_oe) |-> {1'b0, low_cnt} + 9'h001 >= {3'h0, div[5:0]};
  endproperty
  a_low_time: assert property (p_low_time) else $error("clock low too short");
  property p_start_hold;
    $rose(line_out.sda_oe) && !line_out.scl_oe |=> line_out.sda_oe [*3];
  endproperty
  a_start_hold: assert property (p_start_hold) else $error("data not held low");

  // Main scenarios seen
  c_start: cover property ($rose(line_out.sda_oe) && !line_out.scl_oe);
  c_clock: cover property ($rose(line_out.scl_oe));
  c_write: cover property (bus_req.write && !bus_rsp.waitrequest);
endmodule : i2c_seq_asserts

bind i2c_master_sequencer i2c_seq_asserts chk_u (.core_clk(core_clk), .rst(rst),
  .bus_req(bus_req), .bus_rsp(bus_rsp), .line_in(line_in), .line_out(line_out));
`default_nettype wire

//--- sim/i2c_slave_model.sv
// Behavioural slave on the far side of the two-wire lines
`default_nettype none
module i2c_slave_model
(
  // Clock and settings from the bench
  input wire logic core_clk,
  input wire logic arm,
  input wire logic nack,
  input wire logic rx_mode,
  input wire logic stretch,
  input wire logic [7:0] rx_byte,
  // Resolved lines, pulls and captured byte
  input wire logic scl,
  input wire logic sda,
  output logic scl_pull,
  output logic sda_pull,
  output logic [7:0] got
);
  timeunit 1ns;
  timeprecision 1ps;
  int rises = 0;
  int idx = 8;
  logic ack_pull = 1'b0;

  // Bit counting restarts per byte
  always @(posedge arm)
  begin
    rises = 0;
    idx = 0;
    ack_pull = 1'b0;
  end
  always @(posedge scl)
  begin
    if (rises < 8)
      got = {got[6:0], sda};
    rises++;
  end
  always @(negedge scl)
  begin
    idx = rises;
    ack_pull = rises == 8 && !nack && !rx_mode;
    if (stretch)
    begin
      scl_pull = 1'b1;
      repeat (16) @(posedge core_clk);
      scl_pull = 1'b0;
    end
  end
  initial
    scl_pull = 1'b0;
  // bits change while clock low; released line floats high
  assign sda_pull = ack_pull || (rx_mode && idx < 8 && !rx_byte[7 - idx]);
endmodule : i2c_slave_model
`default_nettype wire

//--- sim/i2c_master_start_tx_rx_sequencer_test.sv
// Self-checking bench: registers, start, restart, send and receive
`default_nettype none
module i2c_master_start_tx_rx_sequencer_test import i2c_seq_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rst, arm, nack, rx_mode, stretch, scl_pull, sda_pull;
  avs_req_t req;
  avs_rsp_t rsp;
  line_in_t lin;
  line_out_t lout;
  logic [7:0] rx_byte, got, b;
  logic [31:0] q;
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;

  // Open-drain lines with pull-ups
  assign lin = {!(lout.scl_oe | scl_pull), !(lout.sda_oe | sda_pull)};
  i2c_master_sequencer dut_u (.core_clk(core_clk), .rst(rst), .bus_req(req),
    .bus_rsp(rsp), .line_in(lin), .line_out(lout));
  i2c_slave_model slv_u (.core_clk(core_clk), .arm(arm), .nack(nack),
    .rx_mode(rx_mode), .stretch(stretch), .rx_byte(rx_byte), .scl(lin.scl_in),
    .sda(lin.sda_in), .scl_pull(scl_pull), .sda_pull(sda_pull), .got(got));

  ////////////////////////////////////////////////////////////////////////////
  // Bus cycle held until waitrequest is seen low; the global limit cuts hangs
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d,
    output logic [31:0] v);
    req.write <= w;
    req.read <= !w;
    req.address <= a;
    req.writedata <= d;
    @(posedge core_clk);
    while (rsp.waitrequest !== 1'b0)
      @(posedge core_clk);
    v = rsp.readdata;
    req.write <= 1'b0;
    req.read <= 1'b0;
    @(posedge core_clk);
  endtask : acc
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] v;
    acc(1'b0, a, 32'h0, v);
    chk(v, e);
  endtask : rd
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] v;
    acc(1'b1, a, d, v);
  endtask : wr
  // Poll for the interrupt flag, then clear it alone
  task automatic wait_int();
    logic [31:0] v;
    int n;
    n = 0;
    v = 32'h0;
    while (v[SER_INT_POS] !== 1'b1 && n < 400)
    begin
      acc(1'b0, STAT_ADDR, 32'h0, v);
      n++;
    end
    chk({31'h0, v[SER_INT_POS]}, 32'h1);
    wr(STAT_ADDR, 32'h80);
  endtask : wait_int
  task automatic pulse_arm();
    arm <= 1'b1;
    @(posedge core_clk);
    arm <= 1'b0;
  endtask : pulse_arm
  function automatic logic [31:0] stat(input logic bf, sd, wc, ov);
    stat = 32'h0;
    stat[BF_POS] = bf;
    stat[START_DET_POS] = sd;
    stat[WRITE_COLLISION_FLAG_POS] = wc;
    stat[RX_OV_POS] = ov;
  endfunction : stat
  task automatic conclude();
    $display("Mismatches %0d, checks %0d", fail_count, checks_done);
    if (fail_count == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude

  ////////////////////////////////////////////////////////////////////////////
  // Clock and hang limit
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      conclude();
    end
  end

  // Main sequence
  initial
  begin
    req = '{1'b0, 1'b0, 4'h0, 4'hf, 32'h0};
    {arm, nack, rx_mode, stretch, rx_byte} = 12'h000;
    rst = 1'b1;
    void'($urandom(32'h8503));
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    // Reset values, a hole in the map, divisor for a 160 ns line clock
    rd(CTRL_ADDR, 32'h0);
    rd(STAT_ADDR, 32'h0);
    rd(DIV_ADDR, 32'h3f);
    wr(4'h6, 32'hff);
    rd(4'h6, 32'h0);
    wr(DIV_ADDR, 32'h9);
    // Start with a control write and a buffer write refused behind it
    wr(CTRL_ADDR, 32'h1);
    wr(CTRL_ADDR, 32'h8);
    wr(BUF_ADDR, 32'h5a);
    wait_int();
    rd(CTRL_ADDR, 32'h0);
    rd(STAT_ADDR, stat(1'b0, 1'b1, 1'b1, 1'b0));
    chk({31'h0, lout.sda_oe}, 32'h1);
    wr(STAT_ADDR, 32'h10);
    rd(STAT_ADDR, stat(1'b0, 1'b1, 1'b0, 1'b0));
    // Bytes: random, all ones refused, random with a stretching slave
    for (int i = 0; i < 3; i++)
    begin
      b = (i == 1) ? 8'hff : 8'($urandom());
      nack <= (i == 1);
      stretch <= (i == 2);
      pulse_arm();
      wr(BUF_ADDR, {24'h0, b});
      wr(BUF_ADDR, {24'h0, ~b});
      rd(STAT_ADDR, stat(1'b1, 1'b1, 1'b1, 1'b0));
      wait_int();
      chk({24'h0, got}, {24'h0, b});
      rd(CTRL_ADDR, {25'h0, nack, 6'h0});
      rd(STAT_ADDR, stat(1'b0, 1'b1, 1'b1, 1'b0));
      rd(BUF_ADDR, {24'h0, b});
      chk({31'h0, lout.scl_oe}, 32'h1);
      wr(STAT_ADDR, 32'h10);
    end
    // Receptions: read out and acknowledged, left unread, then overflow
    stretch <= 1'b0;
    rx_mode <= 1'b1;
    for (int j = 0; j < 3; j++)
    begin
      b = 8'($urandom());
      rx_byte <= b;
      pulse_arm();
      wr(CTRL_ADDR, 32'h8);
      wait_int();
      rd(CTRL_ADDR, 32'h0);
      rd(STAT_ADDR, stat(1'b1, 1'b1, 1'b0, j == 2));
      if (j != 1)
      begin
        rd(BUF_ADDR, {24'h0, b});
        rd(STAT_ADDR, stat(1'b0, 1'b1, 1'b0, j == 2));
      end
      if (j == 0)
      begin
        wr(CTRL_ADDR, 32'h10);
        wait_int();
        rd(CTRL_ADDR, 32'h0);
      end
    end
    // Stop clears start-detected; a restart asked for inside it is dropped
    rx_mode <= 1'b0;
    wr(STAT_ADDR, 32'hf0);
    wr(CTRL_ADDR, 32'h4);
    wr(CTRL_ADDR, 32'h2);
    wait_int();
    rd(CTRL_ADDR, 32'h0);
    rd(STAT_ADDR, stat(1'b0, 1'b0, 1'b0, 1'b0));
    // Repeated start; a start asked for inside it has no effect
    wr(CTRL_ADDR, 32'h2);
    wr(CTRL_ADDR, 32'h1);
    wait_int();
    rd(CTRL_ADDR, 32'h0);
    rd(STAT_ADDR, stat(1'b0, 1'b1, 1'b0, 1'b0));
    chk({31'h0, lout.sda_oe}, 32'h1);
    // Start while data is still low collides, aborts and frees the lines
    wr(CTRL_ADDR, 32'h1);
    acc(1'b0, STAT_ADDR, 32'h0, q);
    chk({31'h0, q[BUS_COLL_POS]}, 32'h1);
    rd(CTRL_ADDR, 32'h0);
    chk({31'h0, lout.sda_oe}, 32'h0);
    wr(STAT_ADDR, 32'hf0);
    // Lines free again, so a fresh start completes
    wr(CTRL_ADDR, 32'h1);
    wait_int();
    rd(CTRL_ADDR, 32'h0);
    chk({31'h0, lout.sda_oe}, 32'h1);
    conclude();
  end
endmodule : i2c_master_start_tx_rx_sequencer_test
`default_nettype wire
